// ### nds_pkg.sv
// package: register map, fields, resets and timing of the diagnostic block
package nds_pkg;

    // ============================================================
    // register byte offsets
    localparam logic [7:0] NDS_OFF_DIAG    = 8'h00;
    localparam logic [7:0] NDS_OFF_CONFIG  = 8'h04;
    localparam logic [7:0] NDS_OFF_SETUP   = 8'h08;
    localparam logic [7:0] NDS_OFF_COMMAND = 8'h0C;
    localparam logic [7:0] NDS_OFF_INT_STS = 8'h10;
    localparam logic [7:0] NDS_OFF_INT_MSK = 8'h14;
    localparam logic [7:0] NDS_OFF_NODE_ID = 8'h18;
    localparam logic [7:0] NDS_OFF_PROBE   = 8'h1C;
    localparam logic [7:0] NDS_OFF_SUCC_ID = 8'h20;

    // ============================================================
    // diagnostic register bit positions
    localparam int NDS_DG_OWN_RECONFIG = 7;
    localparam int NDS_DG_DUP_ID       = 6;
    localparam int NDS_DG_RX_ACT       = 5;
    localparam int NDS_DG_TOKEN_SEEN   = 4;
    localparam int NDS_DG_EXCESS_REF   = 3;
    localparam int NDS_DG_PROBE_MATCH  = 2;
    localparam int NDS_DG_SUCC_CHANGE  = 1;
    localparam int NDS_DG_DUP_DONE     = 0;

    // configuration, setup and command bit positions
    localparam int NDS_CF_TX_ENABLE = 5;
    localparam int NDS_CF_ET_LO     = 0;
    localparam int NDS_CF_ET_HI     = 1;
    localparam int NDS_SU_FOUR_REF  = 0;
    localparam int NDS_CM_DISABLE_TX = 0;
    localparam int NDS_CM_CLEAR_FLAGS = 1;
    localparam int NDS_CM_START_TX   = 2;

    // interrupt status / mask bit positions
    localparam int NDS_IRQ_W          = 6;
    localparam int NDS_IS_RECONFIG    = 0;
    localparam int NDS_IS_EXCESS_REF  = 1;
    localparam int NDS_IS_DUP_ID      = 2;
    localparam int NDS_IS_TX_AVAIL    = 3;
    localparam int NDS_IS_SUCC_CHANGE = 4;
    localparam int NDS_IS_DUP_DONE    = 5;

    // ============================================================
    // reset values
    localparam logic [7:0]          NDS_RST_CONFIG = 8'h00;
    localparam logic [7:0]          NDS_RST_SETUP  = 8'h00;
    localparam logic [7:0]          NDS_RST_ID     = 8'h00;
    localparam logic [NDS_IRQ_W-1:0] NDS_RST_MASK  = 6'h00;

    // ============================================================
    // refusal thresholds
    localparam int NDS_REFUSE_LONG  = 128;
    localparam int NDS_REFUSE_SHORT = 4;

    // ============================================================
    // duplicate identity wait, in ms, and derived cycle counts at 250 MHz
    localparam longint NDS_CLK_HZ        = 250000000;
    localparam longint NDS_DUP_WAIT_MS   = 840;
    localparam longint NDS_DUP_WAIT_X_MS = 1680;
    localparam longint NDS_DUP_SHORT_CYC = NDS_DUP_WAIT_MS * NDS_CLK_HZ / 1000;
    localparam longint NDS_DUP_LONG_CYC  = NDS_DUP_WAIT_X_MS * NDS_CLK_HZ / 1000;
    localparam int     NDS_TMR_W         = 29;

    typedef enum logic [0:0] {
        NDS_BUS_IDLE = 1'b0,
        NDS_BUS_WAIT = 1'b1
    } nds_bus_state_t;

endpackage : nds_pkg

// ### nds_refusal_counter.sv
// file: consecutive refusal counter with selectable wrap threshold
`timescale 1ns/1ps
module nds_refusal_counter
    import nds_pkg::*;
#(
    parameter int LONG_COUNT  = NDS_REFUSE_LONG,
    parameter int SHORT_COUNT = NDS_REFUSE_SHORT
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // answers from the destination, restart and four-refusal select
    input  wire logic refused,
    input  wire logic accepted,
    input  wire logic restart,
    input  wire logic four_sel,
    // threshold reached
    output logic      hit
);

    initial begin
        if (LONG_COUNT < 2 || LONG_COUNT > 256 || SHORT_COUNT < 2 || SHORT_COUNT > LONG_COUNT)
            $error("nds_refusal_counter: thresholds out of range");
    end

    typedef struct packed {
        logic [7:0] count;
        logic       hit;
    } nds_rc_state_t;

    nds_rc_state_t q;
    nds_rc_state_t d;

    localparam logic [7:0] LAST_LONG  = 8'(LONG_COUNT - 1);
    localparam logic [7:0] LAST_SHORT = 8'(SHORT_COUNT - 1);

    always_comb begin
        d     = q;
        d.hit = 1'b0;
        if (restart || accepted) begin
            // any other answer breaks the run of refusals
            d.count = 8'h00;
        end else if (refused) begin
            if (q.count == (four_sel ? LAST_SHORT : LAST_LONG)) begin
                d.hit   = 1'b1;
                d.count = 8'h00;
            end else begin
                d.count = q.count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign hit = q.hit;

endmodule : nds_refusal_counter

// ### nds_diag_top.sv
// file: network diagnostic status block, apb slave and interrupt
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - own token timer expiry sets the own-reconfiguration flag.
// - reconfigurations interrupt the host via the reconfiguration status bit.
// - reading the diagnostic register clears the own-reconfiguration flag.
// - configuration bit 5 enables the basic transmit function.
// - a high level on the line receive input sets receive activity.
// - any token from another node sets token seen.
// - 128 (or 4) consecutive refusals set excess refusal and interrupt.
// - setup register's four-refusal select bit picks the threshold.
// - after disable transmitter, next own token sets transmitter available.
// - clear-flags resets excess refusal; counter wraps and can set it again.
// - successor-change flag reports nodes leaving or joining.
// - probe identity answered by another node sets probe match.
// - duplicate identity found within 840 ms, or 1680 ms unless both timeout bits set.
// - reading the diagnostic register clears the duplicate identity flag.
module nds_diag_top
    import nds_pkg::*;
#(
    parameter longint DUP_SHORT_CYC = NDS_DUP_SHORT_CYC,
    parameter longint DUP_LONG_CYC  = NDS_DUP_LONG_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // line pin
    input  wire logic        line_receive_input,
    // events from the protocol engine, one-cycle pulses
    input  wire logic        token_timer_expired,
    input  wire logic        reconfig_seen,
    input  wire logic        token_observed,
    input  wire logic        token_from_self,
    input  wire logic        own_token_received,
    input  wire logic        enquiry_refused,
    input  wire logic        enquiry_accepted,
    input  wire logic        response_seen,
    input  wire logic [7:0]  response_did,
    input  wire logic        successor_valid,
    input  wire logic [7:0]  successor_id,
    // controls to the protocol engine
    output logic             transmit_enable,
    output logic             tx_abort,
    output logic             tx_start,
    output logic [7:0]       node_identity,
    // interrupt
    output logic             irq
);

    // ============================================================
    // parameter checks
    localparam longint TMR_MAX = longint'(1) << NDS_TMR_W;

    initial begin
        if (DUP_SHORT_CYC < 1 || DUP_LONG_CYC < DUP_SHORT_CYC || DUP_LONG_CYC >= TMR_MAX)
            $error("nds_diag_top: duplicate wait counts out of range");
    end

    localparam logic [NDS_TMR_W-1:0] SHORT_LAST = NDS_TMR_W'(DUP_SHORT_CYC - 1);
    localparam logic [NDS_TMR_W-1:0] LONG_LAST  = NDS_TMR_W'(DUP_LONG_CYC - 1);

    // ============================================================
    // reset release
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ============================================================
    // state
    typedef struct packed {
        nds_bus_state_t         bus;
        logic [31:0]            rdata;
        logic                   ready;
        logic                   slverr;
        logic                   rx_meta;
        logic                   rx_sync;
        logic                   own_reconfig;
        logic                   dup_id;
        logic                   rx_act;
        logic                   token_seen;
        logic                   excess_ref;
        logic                   probe_match;
        logic                   succ_change;
        logic                   dup_done;
        logic                   dup_run;
        logic [NDS_TMR_W-1:0]   dup_tmr;
        logic                   avail_pending;
        logic                   tx_avail;
        logic [7:0]             cfg;
        logic [7:0]             setup;
        logic [7:0]             node_id;
        logic [7:0]             probe_id;
        logic [7:0]             succ_id;
        logic [NDS_IRQ_W-1:0]   int_sts;
        logic [NDS_IRQ_W-1:0]   int_msk;
        logic                   abort;
        logic                   start;
        logic                   irq;
    } nds_state_t;

    nds_state_t q;
    nds_state_t d;

    logic refusal_hit;

    // ============================================================
    // helpers
    function automatic logic [7:0] diag_word(input nds_state_t s);
        logic [7:0] w;
        w                      = 8'h00;
        w[NDS_DG_OWN_RECONFIG] = s.own_reconfig;
        w[NDS_DG_DUP_ID]       = s.dup_id;
        w[NDS_DG_RX_ACT]       = s.rx_act;
        w[NDS_DG_TOKEN_SEEN]   = s.token_seen;
        w[NDS_DG_EXCESS_REF]   = s.excess_ref;
        w[NDS_DG_PROBE_MATCH]  = s.probe_match;
        w[NDS_DG_SUCC_CHANGE]  = s.succ_change;
        w[NDS_DG_DUP_DONE]     = s.dup_done;
        return w;
    endfunction : diag_word

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction : hits

    // ============================================================
    // refusal counting
    logic wr_cmd;
    logic cmd_abort;
    logic cmd_start;
    logic cmd_clear;
    logic bus_done;
    logic rd_diag;

    assign bus_done  = psel && penable && q.ready;
    assign wr_cmd    = bus_done && pwrite && hits(paddr, NDS_OFF_COMMAND);
    assign cmd_abort = wr_cmd && pwdata[NDS_CM_DISABLE_TX];
    assign cmd_start = wr_cmd && pwdata[NDS_CM_START_TX];
    assign cmd_clear = wr_cmd && pwdata[NDS_CM_CLEAR_FLAGS];
    assign rd_diag   = bus_done && !pwrite && hits(paddr, NDS_OFF_DIAG);

    nds_refusal_counter #(
        .LONG_COUNT  (NDS_REFUSE_LONG),
        .SHORT_COUNT (NDS_REFUSE_SHORT)
    ) u_refusal (
        .clk      (clk),
        .rst_n    (rst_n),
        .refused  (enquiry_refused),
        .accepted (enquiry_accepted),
        .restart  (cmd_abort || cmd_start),
        .four_sel (q.setup[NDS_SU_FOUR_REF]),
        .hit      (refusal_hit)
    );

    // ============================================================
    // next state
    always_comb begin
        logic [NDS_IRQ_W-1:0] ev;
        logic [7:0]           rd;
        logic                 known;
        ev    = '0;
        rd    = 8'h00;
        known = 1'b1;
        d     = q;

        d.abort = cmd_abort;
        d.start = cmd_start;

        // line pin synchroniser
        d.rx_meta = line_receive_input;
        d.rx_sync = q.rx_meta;

        // read-clear first: a same-cycle event still sets its flag
        if (rd_diag) begin
            d.own_reconfig = 1'b0;
            d.dup_id       = 1'b0;
            d.rx_act       = 1'b0;
            d.token_seen   = 1'b0;
            d.probe_match  = 1'b0;
            d.succ_change  = 1'b0;
        end
        if (cmd_clear) begin
            d.excess_ref = 1'b0;
        end

        if (token_timer_expired) begin
            d.own_reconfig = 1'b1;
        end
        if (q.rx_sync) begin
            d.rx_act = 1'b1;
        end
        if (token_observed && !token_from_self) begin
            d.token_seen = 1'b1;
        end
        if (refusal_hit) begin
            d.excess_ref = 1'b1;
        end
        if (response_seen && response_did == q.probe_id && q.probe_id != 8'h00) begin
            d.probe_match = 1'b1;
        end
        // a reply to a token for our own id means another node holds it
        if (response_seen && response_did == q.node_id && q.node_id != 8'h00
            && !q.cfg[NDS_CF_TX_ENABLE]) begin
            d.dup_id = 1'b1;
            ev[NDS_IS_DUP_ID] = 1'b1;
        end
        if (successor_valid && successor_id != q.succ_id) begin
            d.succ_id     = successor_id;
            d.succ_change = 1'b1;
            ev[NDS_IS_SUCC_CHANGE] = 1'b1;
        end

        // duplicate check window; the done bit marks a final answer
        if (q.dup_run) begin
            if (q.dup_tmr == ((q.cfg[NDS_CF_ET_HI] && q.cfg[NDS_CF_ET_LO])
                              ? SHORT_LAST : LONG_LAST)) begin
                d.dup_run  = 1'b0;
                d.dup_done = 1'b1;
                ev[NDS_IS_DUP_DONE] = 1'b1;
            end else begin
                d.dup_tmr = q.dup_tmr + NDS_TMR_W'(1);
            end
        end

        // transmitter available once our token returns after an abort
        if (cmd_abort) begin
            d.avail_pending = 1'b1;
            d.tx_avail      = 1'b0;
        end else if (cmd_start) begin
            d.avail_pending = 1'b0;
            d.tx_avail      = 1'b0;
        end
        if (q.avail_pending && own_token_received) begin
            d.avail_pending = 1'b0;
            d.tx_avail      = 1'b1;
            ev[NDS_IS_TX_AVAIL] = 1'b1;
        end

        ev[NDS_IS_RECONFIG]   = token_timer_expired || reconfig_seen;
        ev[NDS_IS_EXCESS_REF] = refusal_hit;

        // ========================================================
        // apb slave: no wait state, answer registered in the setup cycle
        d.ready  = 1'b0;
        d.slverr = 1'b0;
        case (q.bus)
            NDS_BUS_IDLE: begin
                if (psel && !penable) begin
                    case (paddr)
                        NDS_OFF_DIAG:    rd = diag_word(q);
                        NDS_OFF_CONFIG:  rd = q.cfg;
                        NDS_OFF_SETUP:   rd = q.setup;
                        NDS_OFF_COMMAND: rd = {7'h00, q.tx_avail};
                        NDS_OFF_INT_STS: rd = 8'(q.int_sts);
                        NDS_OFF_INT_MSK: rd = 8'(q.int_msk);
                        NDS_OFF_NODE_ID: rd = q.node_id;
                        NDS_OFF_PROBE:   rd = q.probe_id;
                        NDS_OFF_SUCC_ID: rd = q.succ_id;
                        default:         known = 1'b0;
                    endcase
                    d.rdata  = pwrite ? 32'h0000_0000 : {24'h000000, rd};
                    d.ready  = 1'b1;
                    d.slverr = !known;
                    d.bus    = NDS_BUS_WAIT;
                end
            end
            NDS_BUS_WAIT: begin
                if (bus_done) begin
                    d.bus   = NDS_BUS_IDLE;
                    d.rdata = 32'h0000_0000;
                    if (pwrite) begin
                        case (paddr)
                            NDS_OFF_CONFIG:  d.cfg = pwdata[7:0];
                            NDS_OFF_SETUP:   d.setup  = pwdata[7:0];
                            NDS_OFF_INT_MSK: d.int_msk = pwdata[NDS_IRQ_W-1:0];
                            NDS_OFF_PROBE:   d.probe_id = pwdata[7:0];
                            NDS_OFF_NODE_ID: begin
                                d.node_id  = pwdata[7:0];
                                d.dup_run  = pwdata[7:0] != 8'h00;
                                d.dup_done = 1'b0;
                                d.dup_tmr  = '0;
                            end
                            NDS_OFF_INT_STS: d.int_sts = q.int_sts & ~pwdata[NDS_IRQ_W-1:0];
                            default: ;
                        endcase
                    end
                end else begin
                    d.ready = q.ready;
                end
            end
            default: begin
                d.bus = NDS_BUS_IDLE;
            end
        endcase

        // events win over a write-one clear in the same cycle
        d.int_sts = d.int_sts | ev;
        d.irq     = |(d.int_sts & d.int_msk);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q         <= '0;
            q.bus     <= NDS_BUS_IDLE;
            q.cfg     <= NDS_RST_CONFIG;
            q.setup   <= NDS_RST_SETUP;
            q.node_id <= NDS_RST_ID;
            q.int_msk <= NDS_RST_MASK;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // outputs, all straight from state flops
    assign prdata          = q.rdata;
    assign pready          = q.ready;
    assign pslverr         = q.slverr;
    assign transmit_enable = q.cfg[NDS_CF_TX_ENABLE];
    assign tx_abort        = q.abort;
    assign tx_start        = q.start;
    assign node_identity   = q.node_id;
    assign irq             = q.irq;

endmodule : nds_diag_top

// ### nds_diag_monitor.sv
// checker: apb and control-output properties of the diagnostic block
`timescale 1ns/1ps
module nds_diag_monitor
    import nds_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // controls and interrupt
    input wire logic        transmit_enable,
    input wire logic        tx_abort,
    input wire logic        tx_start,
    input wire logic [7:0]  node_identity,
    input wire logic        irq
);
    // ============================================================
    // properties
    logic wr;
    logic cw;
    assign wr = psel && penable && pready && pwrite;
    assign cw = wr && paddr == NDS_OFF_COMMAND;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ready_one_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    transmit_enable_bit_write_a: assert property (wr && paddr == NDS_OFF_CONFIG |=>
        transmit_enable == $past(pwdata[NDS_CF_TX_ENABLE]))
        else $error("transmit enable not taken");
    abort_pulse_a: assert property (cw && pwdata[0] |=> tx_abort ##1 !tx_abort)
        else $error("abort pulse wrong");
    start_pulse_a: assert property (cw && pwdata[2] |=> tx_start ##1 !tx_start)
        else $error("start pulse wrong");
    node_id_a: assert property (wr && paddr == NDS_OFF_NODE_ID |=>
        node_identity == $past(pwdata[7:0]))
        else $error("node identity not taken");
    irq_sticky_a: assert property (irq && !(wr && paddr inside {8'h10, 8'h14})
        && !$past(wr && paddr inside {8'h10, 8'h14}) |=> irq)
        else $error("interrupt dropped without host write");
endmodule : nds_diag_monitor

bind nds_diag_top nds_diag_monitor u_mon (.*);

// ### nds_net_model.sv
// model: destination node with no free buffer, refusing every enquiry
`timescale 1ns/1ps
module nds_net_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // transmit controls from the block
    input wire logic tx_start,
    input wire logic tx_abort,
    // answer
    output logic     enquiry_refused
);
    logic       act_q;
    logic [1:0] gap_q;
    // one refusal every fourth cycle leaves room for the flag pipeline
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_q           <= 1'h0;
            gap_q           <= 2'h0;
            enquiry_refused <= 1'h0;
        end else begin
            gap_q           <= gap_q + 2'h1;
            act_q           <= tx_start | (act_q & ~tx_abort);
            enquiry_refused <= act_q && gap_q == 2'h3;
        end
    end
endmodule : nds_net_model

// ### network_diagnostic_status_tb.sv
// testbench: apb-driven checks of the diagnostic status block
`timescale 1ns/1ps
module network_diagnostic_status_tb
    import nds_pkg::*;
;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err, irq;
    logic [7:0]  paddr, response_did, successor_id, node_identity, s, p;
    logic [31:0] pwdata, prdata, r, seed;
    logic        line_receive_input, token_timer_expired, reconfig_seen;
    logic        token_observed, token_from_self, own_token_received;
    logic        enquiry_refused, enquiry_accepted, response_seen, successor_valid;
    logic        transmit_enable, tx_abort, tx_start;
    int          bad_count, checks, nref, base;

    nds_diag_top #(.DUP_SHORT_CYC(20), .DUP_LONG_CYC(40)) dut (.clk, .arst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .line_receive_input, .token_timer_expired, .reconfig_seen, .token_observed,
        .token_from_self, .own_token_received, .enquiry_refused, .enquiry_accepted,
        .response_seen, .response_did, .successor_valid, .successor_id,
        .transmit_enable, .tx_abort, .tx_start, .node_identity, .irq);
    nds_net_model u_net (.clk, .arst_n, .tx_start, .tx_abort, .enquiry_refused);

    // ============================================================
    // helpers
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    function automatic int thr(input int sel);
        return (sel != 0) ? NDS_REFUSE_SHORT : NDS_REFUSE_LONG;
    endfunction : thr
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        if (n >= 64) bad_count++;
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        // one idle edge keeps a following call from driving psel twice at once
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask : rd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic resp(input logic [7:0] d);
        response_did <= d;
        response_seen <= 1'h1;
        tick(1);
        response_seen <= 1'h0;
        tick(2);
    endtask : resp
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'h1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_irq
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ============================================================
    // clock, refusal count, watchdog
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (enquiry_refused === 1'h1) nref <= nref + 1;
    // run takes ~1.3k cycles; far past that is a hang
    initial begin
        tick(20000);
        bad_count++;
        end_of_test();
    end

    // ============================================================
    // tests
    initial begin
        {arst_n, psel, penable, pwrite, line_receive_input, token_timer_expired} = '0;
        {reconfig_seen, token_observed, token_from_self, own_token_received} = '0;
        {enquiry_accepted, response_seen, successor_valid} = '0;
        {paddr, response_did, successor_id, pwdata} = '0;
        {bad_count, checks, nref} = '0;
        seed = 32'hEC3BABFD;
        tick(4);
        arst_n <= 1'h1;
        tick(3);
        for (int a = 0; a < 36; a += 4) begin
            rd(8'(a));
            chk(r, 32'h0);
        end
        rd(8'h40);
        chk(err, 1'h1);
        $display("test reset done");
        wr(NDS_OFF_INT_MSK, 32'h1);
        {token_timer_expired, reconfig_seen} <= 2'h3;
        tick(1);
        {token_timer_expired, reconfig_seen} <= 2'h0;
        tick(3);
        chk(irq, 1'h1);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_OWN_RECONFIG], 1'h1);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_OWN_RECONFIG], 1'h0);
        wr(NDS_OFF_INT_STS, 32'h1);
        tick(2);
        chk(irq, 1'h0);
        $display("test reconfig done");
        for (int k = 0; k < 2; k++) begin
            token_observed <= 1'h1;
            token_from_self <= (k == 0);
            line_receive_input <= (k == 1);
            tick(1);
            {token_observed, line_receive_input} <= 2'h0;
            tick(4);
            rd(NDS_OFF_DIAG);
            chk(r[NDS_DG_TOKEN_SEEN], k);
            chk(r[NDS_DG_RX_ACT], k);
        end
        $display("test activity done");
        seed = nxt(seed);
        s = seed[7:0] | 8'h01;
        for (int k = 0; k < 2; k++) begin
            {successor_id, successor_valid} <= {s, 1'h1};
            tick(1);
            successor_valid <= 1'h0;
            tick(2);
            rd(NDS_OFF_DIAG);
            chk(r[NDS_DG_SUCC_CHANGE], k == 0);
        end
        rd(NDS_OFF_SUCC_ID);
        chk(r, {24'h0, s});
        seed = nxt(seed);
        p = seed[7:0] | 8'h01;
        wr(NDS_OFF_PROBE, p);
        resp(p);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_PROBE_MATCH], 1'h1);
        $display("test successor and probe done");
        s = p ^ 8'h40;
        wr(NDS_OFF_CONFIG, 32'h3);
        wr(NDS_OFF_NODE_ID, s);
        resp(s);
        tick(10);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_DUP_ID], 1'h1);
        chk(r[NDS_DG_DUP_DONE], 1'h0);
        tick(12);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_DUP_DONE], 1'h1);
        chk(r[NDS_DG_DUP_ID], 1'h0);
        wr(NDS_OFF_CONFIG, 32'h0);
        wr(NDS_OFF_NODE_ID, s);
        tick(22);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_DUP_DONE], 1'h0);
        tick(18);
        rd(NDS_OFF_DIAG);
        chk(r[NDS_DG_DUP_DONE], 1'h1);
        $display("test duplicate done");
        wr(NDS_OFF_CONFIG, 32'h20);
        tick(1);
        chk(transmit_enable, 1'h1);
        rd(NDS_OFF_CONFIG);
        chk(r, 32'h20);
        wr(NDS_OFF_INT_MSK, 32'h2);
        for (int i = 1; i >= 0; i--) begin
            wr(NDS_OFF_SETUP, i);
            base = nref;
            wr(NDS_OFF_COMMAND, 32'h4);
            wait_irq();
            chk(nref - base, thr(i));
            rd(NDS_OFF_DIAG);
            chk(r[NDS_DG_EXCESS_REF], 1'h1);
            wr(NDS_OFF_INT_STS, 32'h2);
            wr(NDS_OFF_COMMAND, 32'h2);
            tick(2);
            wait_irq();
            chk(nref - base, 2 * thr(i));
            wr(NDS_OFF_COMMAND, 32'h1);
            tick(2);
            wr(NDS_OFF_INT_STS, 32'h3F);
        end
        $display("test refusals done");
        rd(NDS_OFF_INT_STS);
        chk(r[NDS_IS_TX_AVAIL], 1'h0);
        own_token_received <= 1'h1;
        tick(1);
        own_token_received <= 1'h0;
        tick(2);
        rd(NDS_OFF_INT_STS);
        chk(r[NDS_IS_TX_AVAIL], 1'h1);
        rd(NDS_OFF_COMMAND);
        chk(r[0], 1'h1);
        $display("test transmitter available done");
        end_of_test();
    end
endmodule : network_diagnostic_status_tb
